// ==== psc_regs.svh ====
`ifndef PSC_REGS_SVH
`define PSC_REGS_SVH

// system clock
`define PSC_CLK_PERIOD_NS 8

// timing figures in their own units
`define PSC_T_POR_MIN_MS 12
`define PSC_T_STATUS_MIN_US 10
`define PSC_T_REL_MAX_US 100
`define PSC_T_UM_MIN_US 20
`define PSC_T_UM_MAX_US 40
`define PSC_SCLK_PERIOD_MAX_NS 10
`define PSC_CU_PERIODS 4
`define PSC_USR_PERIODS 299

// least times round up, longest times round down
`define PSC_CEIL_CYC(ns) (((ns) + `PSC_CLK_PERIOD_NS - 1) / `PSC_CLK_PERIOD_NS)
`define PSC_FLOOR_CYC(ns) ((ns) / `PSC_CLK_PERIOD_NS)

`define PSC_POR_CYC `PSC_CEIL_CYC(`PSC_T_POR_MIN_MS * 1000000)
`define PSC_STATUS_CYC `PSC_CEIL_CYC(`PSC_T_STATUS_MIN_US * 1000)
`define PSC_REL_MAX_CYC `PSC_FLOOR_CYC(`PSC_T_REL_MAX_US * 1000)
`define PSC_UM_CYC `PSC_CEIL_CYC(`PSC_T_UM_MIN_US * 1000)
`define PSC_UM_MAX_CYC `PSC_FLOOR_CYC(`PSC_T_UM_MAX_US * 1000)
`define PSC_CU_CYC `PSC_CEIL_CYC(`PSC_CU_PERIODS * `PSC_SCLK_PERIOD_MAX_NS)

// storage defaults
`define PSC_CFG_BITS 1024
`define PSC_WORD_W 8

`endif

// ==== psc_pkg.sv ====
package psc_pkg;

	typedef enum logic [4:0] {
		PSC_POR = 5'h01,
		PSC_RST = 5'h02,
		PSC_CFG = 5'h04,
		PSC_INIT = 5'h08,
		PSC_USER = 5'h10
	} psc_state_e;

	// pins arriving from outside the clock domain
	typedef struct packed {
		logic req_n;
		logic sclk;
		logic sdata;
		logic uclk;
		logic status;
	} psc_pins_s;

	// one pad: value driven, enable low while driving
	typedef struct packed {
		logic dout;
		logic oe_n;
	} psc_od_s;

endpackage : psc_pkg

// ==== psc_cfg_mem.sv ====
`timescale 1ns/10ps

module psc_cfg_mem #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 128
) (
	input wire logic sys_clk_i,
	input wire logic ce_i,
	input wire logic wr_en_i,
	input wire logic [$clog2(DEPTH)-1:0] wr_addr_i,
	input wire logic [WIDTH-1:0] wr_data_i,
	input wire logic [$clog2(DEPTH)-1:0] rd_addr_i,
	output logic [WIDTH-1:0] rd_data_o
);

	logic [WIDTH-1:0] mem_r [DEPTH];

	initial begin
		if (WIDTH < 1 || DEPTH < 2)
			$error("psc_cfg_mem: bad geometry");
	end

	// no reset on the array so it maps onto block ram
	always_ff @(posedge sys_clk_i) begin
		if (ce_i) begin
			if (wr_en_i)
				mem_r[wr_addr_i] <= wr_data_i;
			rd_data_o <= mem_r[rd_addr_i];
		end
	end

endmodule : psc_cfg_mem

// ==== psc_top.sv ====
`timescale 1ns/10ps
`include "psc_regs.svh"

// Contract
// - in user mode request, status, done sit high; request low restarts configuration.
// - after power-up status is held low for the whole power-on delay.
// - done stays low from power-up through the entire data transfer.
// - after configuration the data pin becomes user i/o per dual-purpose setting.
// - within 800 ns of request low, done and status go low.
// - status stays low at least 10 us during a reconfiguration reset.
// - status released within 100 us after request returns high.
// - internal start-up enters user mode 20 to 40 us after done high.
// - user start-up clock enabled four maximum serial-clock periods after done.
// - user mode follows 299 user start-up clock periods after enabling.
// - each data bit is captured on the serial clock rising edge.
// - a configuration error drives status low and resets the device.
module psc_top import psc_pkg::*; #(
	parameter int POR_CYC = `PSC_POR_CYC,
	parameter int CFG_BITS = `PSC_CFG_BITS,
	parameter int WORD_W = `PSC_WORD_W,
	parameter int TMR_W = 21
) (
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	input wire logic ce_i,
	input wire psc_pins_s pins_i,
	input wire logic startup_usr_sel_i,
	input wire logic auto_restart_i,
	input wire logic dual_drive_i,
	input wire logic user_dout_i,
	input wire logic cfg_error_i,
	input wire logic [$clog2(CFG_BITS/WORD_W)-1:0] rd_addr_i,
	output psc_od_s status_pin_o,
	output psc_od_s done_pin_o,
	output psc_od_s sdata_pin_o,
	output logic user_mode_o,
	output logic usr_clk_en_o,
	output logic [WORD_W-1:0] rd_data_o
);

	localparam int DEPTH = CFG_BITS / WORD_W;
	localparam int BC_W = $clog2(CFG_BITS);
	localparam int WB = $clog2(WORD_W);
	localparam logic [TMR_W-1:0] POR_LAST = TMR_W'(POR_CYC - 1);
	localparam logic [TMR_W-1:0] STAT_LAST = TMR_W'(`PSC_STATUS_CYC);
	localparam logic [TMR_W-1:0] UM_LAST = TMR_W'(`PSC_UM_CYC - 1);
	localparam logic [TMR_W-1:0] CU_LAST = TMR_W'(`PSC_CU_CYC - 1);
	localparam logic [8:0] USR_LAST = 9'(`PSC_USR_PERIODS - 1);

	initial begin
		if (POR_CYC < 2 || POR_CYC >= 2 ** TMR_W || `PSC_UM_CYC >= 2 ** TMR_W)
			$error("psc_top: timer too narrow");
		if (WORD_W < 2 || CFG_BITS % WORD_W != 0 || 2 ** BC_W != CFG_BITS || 2 ** WB != WORD_W)
			$error("psc_top: sizes must be powers of two");
	end

	function automatic logic f_rise(input logic prev, input logic cur);
		return !prev && cur;
	endfunction : f_rise

	// synchronisers: s1 feeds only s2
	psc_pins_s s1_r, s2_r, pv_r;
	psc_pins_s s1_nxt, s2_nxt, pv_nxt;

	always_comb begin
		s1_nxt = pins_i;
		s2_nxt = s1_r;
		pv_nxt = s2_r;
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s1_r <= '{req_n: 1'b1, status: 1'b1, default: 1'b0};
			s2_r <= '{req_n: 1'b1, status: 1'b1, default: 1'b0};
			pv_r <= '{req_n: 1'b1, status: 1'b1, default: 1'b0};
		end else if (ce_i) begin
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
			pv_r <= pv_nxt;
		end
	end

	logic req_fell, sclk_rise, uclk_rise;
	assign req_fell = f_rise(!pv_r.req_n, !s2_r.req_n);
	assign sclk_rise = f_rise(pv_r.sclk, s2_r.sclk);
	assign uclk_rise = f_rise(pv_r.uclk, s2_r.uclk);

	// main sequencer
	psc_state_e st_r, st_nxt;
	logic [TMR_W-1:0] tmr_r, tmr_nxt;
	logic [BC_W-1:0] bcnt_r, bcnt_nxt;
	logic [WORD_W-1:0] shr_r, shr_nxt;
	logic [8:0] ucnt_r, ucnt_nxt;
	logic uen_r, uen_nxt;
	logic errh_r, errh_nxt;
	logic umode_r, umode_nxt;
	psc_od_s stat_r, stat_nxt, done_r, done_nxt, sdo_r, sdo_nxt;
	logic wr_en;

	always_comb begin
		st_nxt = st_r;
		tmr_nxt = tmr_r;
		bcnt_nxt = bcnt_r;
		shr_nxt = shr_r;
		ucnt_nxt = ucnt_r;
		uen_nxt = uen_r;
		errh_nxt = errh_r;
		wr_en = 1'b0;
		if (st_r != PSC_POR && req_fell) begin
			st_nxt = PSC_RST;
			tmr_nxt = '0;
			uen_nxt = 1'b0;
			errh_nxt = 1'b0;
		end else begin
			case (st_r)
				PSC_POR: begin
					if (tmr_r == POR_LAST) begin
						st_nxt = PSC_RST;
						tmr_nxt = '0;
					end else begin
						tmr_nxt = tmr_r + 1'b1;
					end
				end
				PSC_RST: begin
					// request low clears a held error so a fresh pulse restarts
					if (!s2_r.req_n)
						errh_nxt = 1'b0;
					if (tmr_r != STAT_LAST) begin
						tmr_nxt = tmr_r + 1'b1;
					end else if (s2_r.req_n && !errh_r) begin
						st_nxt = PSC_CFG;
						bcnt_nxt = '0;
					end
				end
				PSC_CFG: begin
					if (cfg_error_i) begin
						st_nxt = PSC_RST;
						tmr_nxt = '0;
						errh_nxt = !auto_restart_i;
					end else if (sclk_rise && s2_r.status) begin
						// first bit lands in the msb of its word
						shr_nxt = {shr_r[WORD_W-2:0], s2_r.sdata};
						bcnt_nxt = bcnt_r + 1'b1;
						wr_en = &bcnt_r[WB-1:0];
						if (bcnt_r == BC_W'(CFG_BITS - 1)) begin
							st_nxt = PSC_INIT;
							tmr_nxt = '0;
							ucnt_nxt = '0;
							uen_nxt = 1'b0;
						end
					end
				end
				PSC_INIT: begin
					if (!startup_usr_sel_i) begin
						if (tmr_r == UM_LAST)
							st_nxt = PSC_USER;
						else
							tmr_nxt = tmr_r + 1'b1;
					end else if (!uen_r) begin
						if (tmr_r == CU_LAST)
							uen_nxt = 1'b1;
						else
							tmr_nxt = tmr_r + 1'b1;
					end else if (uclk_rise) begin
						if (ucnt_r == USR_LAST)
							st_nxt = PSC_USER;
						else
							ucnt_nxt = ucnt_r + 1'b1;
					end
				end
				PSC_USER: begin
				end
				default: begin
					st_nxt = PSC_POR;
					tmr_nxt = '0;
				end
			endcase
		end
		// pads follow the next state so they line up with st_r
		stat_nxt = '{dout: 1'b0, oe_n: !(st_nxt == PSC_POR || st_nxt == PSC_RST)};
		done_nxt = '{dout: 1'b0, oe_n: (st_nxt == PSC_INIT || st_nxt == PSC_USER)};
		sdo_nxt = '{dout: user_dout_i, oe_n: !(st_nxt == PSC_USER && dual_drive_i)};
		umode_nxt = (st_nxt == PSC_USER);
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_r <= PSC_POR;
			tmr_r <= '0;
			bcnt_r <= '0;
			shr_r <= '0;
			ucnt_r <= '0;
			uen_r <= 1'b0;
			errh_r <= 1'b0;
			umode_r <= 1'b0;
			stat_r <= '{dout: 1'b0, oe_n: 1'b0};
			done_r <= '{dout: 1'b0, oe_n: 1'b0};
			sdo_r <= '{dout: 1'b0, oe_n: 1'b1};
		end else if (ce_i) begin
			st_r <= st_nxt;
			tmr_r <= tmr_nxt;
			bcnt_r <= bcnt_nxt;
			shr_r <= shr_nxt;
			ucnt_r <= ucnt_nxt;
			uen_r <= uen_nxt;
			errh_r <= errh_nxt;
			umode_r <= umode_nxt;
			stat_r <= stat_nxt;
			done_r <= done_nxt;
			sdo_r <= sdo_nxt;
		end
	end

	psc_cfg_mem #(
		.WIDTH(WORD_W),
		.DEPTH(DEPTH)
	) u_mem (
		.sys_clk_i(sys_clk_i),
		.ce_i(ce_i),
		.wr_en_i(wr_en),
		.wr_addr_i(bcnt_r[BC_W-1:WB]),
		.wr_data_i(shr_nxt),
		.rd_addr_i(rd_addr_i),
		.rd_data_o(rd_data_o)
	);

	assign status_pin_o = stat_r;
	assign done_pin_o = done_r;
	assign sdata_pin_o = sdo_r;
	assign user_mode_o = umode_r;
	assign usr_clk_en_o = uen_r;

	// helper counters read only by the checks below
	localparam int STAT_MIN = `PSC_STATUS_CYC;
	localparam int REL_MAX = `PSC_REL_MAX_CYC;
	localparam int UM_MIN = `PSC_UM_CYC;
	localparam int UM_MAX = `PSC_UM_MAX_CYC;
	logic [15:0] lo_cnt_r, lo_cnt_nxt, rel_cnt_r, rel_cnt_nxt, dn_cnt_r, dn_cnt_nxt;

	always_comb begin
		lo_cnt_nxt = stat_r.oe_n ? 16'h0000 : lo_cnt_r + {15'h0000, ~&lo_cnt_r};
		// power-on delay is not a request release, so it is kept out of the bound
		rel_cnt_nxt = (!stat_r.oe_n && s2_r.req_n && !errh_r && st_r != PSC_POR)
			? rel_cnt_r + {15'h0000, ~&rel_cnt_r} : 16'h0000;
		dn_cnt_nxt = !done_r.oe_n ? 16'h0000 : dn_cnt_r + {15'h0000, ~&dn_cnt_r};
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			lo_cnt_r <= 16'h0000;
			rel_cnt_r <= 16'h0000;
			dn_cnt_r <= 16'h0000;
		end else if (ce_i) begin
			lo_cnt_r <= lo_cnt_nxt;
			rel_cnt_r <= rel_cnt_nxt;
			dn_cnt_r <= dn_cnt_nxt;
		end
	end

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!resetn_i || !ce_i);

	sequence s_done_up;
		$rose(done_r.oe_n) && startup_usr_sel_i;
	endsequence
	sequence s_usr_gap;
		!uen_r [*5] ##1 uen_r;
	endsequence

	AST_USER_HIGH: assert property (umode_r |-> stat_r.oe_n && done_r.oe_n)
		else $error("user mode with status or done driven");
	AST_POR_LOW: assert property (st_r == PSC_POR |-> !stat_r.oe_n)
		else $error("status released during power-on delay");
	AST_DONE_LOW: assert property (st_r inside {PSC_POR, PSC_RST, PSC_CFG} |-> !done_r.oe_n)
		else $error("done released before transfer end");
	AST_DATA_REL: assert property (!umode_r |-> sdo_r.oe_n)
		else $error("data pin driven outside user mode");
	AST_REQ_RESP: assert property ($fell(s2_r.req_n) && st_r != PSC_POR |-> ##1 (!stat_r.oe_n && !done_r.oe_n))
		else $error("request low not answered in time");
	AST_STATUS_MIN: assert property ($rose(stat_r.oe_n) |-> lo_cnt_r >= STAT_MIN)
		else $error("status low pulse too short");
	AST_REL_BOUND: assert property (rel_cnt_r <= REL_MAX)
		else $error("status held too long after request high");
	AST_UM_INT: assert property ($rose(umode_r) && !startup_usr_sel_i |-> dn_cnt_r >= UM_MIN && dn_cnt_r <= UM_MAX)
		else $error("internal start-up time out of range");
	AST_USR_EN: assert property (s_done_up |-> s_usr_gap)
		else $error("user start-up clock enable mistimed");
	AST_USR_MODE: assert property ($rose(umode_r) && startup_usr_sel_i |-> $past(uclk_rise) && $past(ucnt_r) == 9'(`PSC_USR_PERIODS - 1))
		else $error("user mode not on user clock count");
	AST_CAPTURE: assert property (st_r == PSC_CFG && sclk_rise && s2_r.status && !cfg_error_i && !req_fell
		|=> bcnt_r == BC_W'($past(bcnt_r) + 1'b1))
		else $error("serial bit not captured");
	AST_ERR: assert property (st_r == PSC_CFG && cfg_error_i && !req_fell |=> st_r == PSC_RST && !stat_r.oe_n)
		else $error("error did not pull status low");

endmodule : psc_top

// ==== psc_top_end_marker_unused.sv ====
`timescale 1ns/10ps

// ==== psc_host_model.sv ====
`timescale 1ns/10ps

module psc_host_model (
	input wire logic sys_clk_i,
	input wire logic status_i,
	output logic req_n_o,
	output logic sclk_o,
	output logic sdata_o,
	output logic uclk_o
);
	realtime req_up_t = 0.0;

	initial begin
		req_n_o = 1'b1;
		sclk_o = 1'b0;
		sdata_o = 1'b0;
		uclk_o = 1'b0;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk_i);
	endtask : cyc

	task automatic pulse_req(input int n);
		cyc(1);
		req_n_o <= 1'b0;
		cyc((n < 250) ? 250 : n);
		req_n_o <= 1'b1;
		req_up_t = $realtime;
	endtask : pulse_req

	// first n bits of d, msb first; clock halves of 80 ns
	task automatic send_bits(input logic [63:0] d, input int n);
		cyc(1);
		while (status_i !== 1'b1) cyc(1);
		cyc(250);
		while ($realtime - req_up_t < 100000.0) cyc(1);
		for (int i = 0; i < n; i++) begin
			sdata_o <= d[63-i];
			cyc(10);
			sclk_o <= 1'b1;
			cyc(10);
			sclk_o <= 1'b0;
		end
		// released line: inverse of last bit, never a stale copy
		sdata_o <= ~sdata_o;
	endtask : send_bits

	task automatic uclk_run(input int n);
		cyc(1);
		repeat (n) begin
			uclk_o <= 1'b1;
			cyc(10);
			uclk_o <= 1'b0;
			cyc(10);
		end
	endtask : uclk_run
endmodule : psc_host_model

// ==== psc_top_test.sv ====
`timescale 1ns/10ps
`include "psc_regs.svh"

module psc_top_test;
	import psc_pkg::*;
	localparam int POR = 40;
	localparam int RST = 1251;
	localparam logic [63:0] PAT = 64'h8142_c3a5_5a3c_e701;
	logic sys_clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic usr_sel = 1'b0;
	logic auto_rst = 1'b0;
	logic dual_drv = 1'b0;
	logic user_dout = 1'b0;
	logic cfg_err = 1'b0;
	logic [2:0] rd_addr = 3'h0;
	psc_od_s status_pin;
	psc_od_s done_pin;
	psc_od_s sdata_pin;
	logic user_mode;
	logic usr_clk_en;
	logic [7:0] rd_data;
	logic req_n;
	logic sclk;
	logic sdata;
	logic uclk;
	int miscompares = 0;
	int cmp_count = 0;
	int cycles = 0;
	int n;

	always #4 sys_clk_i = ~sys_clk_i;

	// edge times, so latencies are measured from the event itself
	realtime done_t = 0.0;
	realtime uen_t = 0.0;
	realtime um_t = 0.0;
	realtime sclk_t = 0.0;
	always @(posedge done_pin.oe_n) done_t = $realtime;
	always @(posedge usr_clk_en) uen_t = $realtime;
	always @(posedge user_mode) um_t = $realtime;
	always @(posedge sclk) sclk_t = $realtime;

	// status and done are open drain with pull-ups: line level equals oe_n
	psc_host_model host (.sys_clk_i(sys_clk_i), .status_i(status_pin.oe_n), .req_n_o(req_n),
		.sclk_o(sclk), .sdata_o(sdata), .uclk_o(uclk));

	psc_top #(.POR_CYC(POR), .CFG_BITS(64)) uut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
		.ce_i(1'b1), .pins_i({req_n, sclk, sdata, uclk, status_pin.oe_n}),
		.startup_usr_sel_i(usr_sel), .auto_restart_i(auto_rst), .dual_drive_i(dual_drv),
		.user_dout_i(user_dout), .cfg_error_i(cfg_err), .rd_addr_i(rd_addr),
		.status_pin_o(status_pin), .done_pin_o(done_pin), .sdata_pin_o(sdata_pin),
		.user_mode_o(user_mode), .usr_clk_en_o(usr_clk_en), .rd_data_o(rd_data));

	task automatic close_out();
		$display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : close_out

	always @(posedge sys_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 90000) begin
			miscompares++;
			close_out();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// sample 1 ns after the edge so the design's updates have landed
	task automatic step(input int k);
		repeat (k) @(posedge sys_clk_i);
		#1;
	endtask : step

	function automatic logic pick(input int w);
		case (w)
			0: return status_pin.oe_n;
			1: return done_pin.oe_n;
			2: return user_mode;
			default: return usr_clk_en;
		endcase
	endfunction : pick

	task automatic wait_hi(input int w, output int c);
		c = 0;
		while (pick(w) !== 1'b1 && c < 30000) begin
			step(1);
			c++;
		end
	endtask : wait_hi

	task automatic t_power_up();
		step(1);
		check(status_pin.oe_n, 1'b0);
		check(done_pin.oe_n, 1'b0);
		wait_hi(0, n);
		check(n >= POR + RST - 2, 1'b1);
		check(n <= POR + RST + 12500, 1'b1);
	endtask : t_power_up

	task automatic t_config(input logic usr, input logic [63:0] pat);
		@(posedge sys_clk_i);
		usr_sel <= usr;
		host.send_bits(pat, 63);
		step(4);
		check(done_pin.oe_n, 1'b0);
		host.send_bits(pat << 63, 1);
		wait_hi(1, n);
		check(n <= 8, 1'b1);
		check(int'((done_t - sclk_t) / 8.0) inside {[2:4]}, 1'b1);
		if (usr) begin
			wait_hi(3, n);
			check(n <= 6, 1'b1);
			check(int'((uen_t - done_t) / 8.0), `PSC_CU_CYC);
			host.uclk_run(298);
			step(10);
			check(user_mode, 1'b0);
			host.uclk_run(1);
			step(1);
			check(user_mode, 1'b1);
		end else begin
			wait_hi(2, n);
			check(n >= 2490 && n <= 5000, 1'b1);
			check(int'((um_t - done_t) / 8.0), `PSC_UM_CYC);
		end
		check({status_pin.oe_n, done_pin.oe_n, req_n}, 3'h7);
		for (int k = 0; k < 8; k++) begin
			@(posedge sys_clk_i);
			rd_addr <= k[2:0];
			step(2);
			check(rd_data, pat[63-8*k -: 8]);
		end
		@(posedge sys_clk_i);
		dual_drv <= 1'b1;
		user_dout <= ~usr;
		step(3);
		check(sdata_pin, {~usr, 1'b0});
		@(posedge sys_clk_i);
		dual_drv <= 1'b0;
		step(3);
		check(sdata_pin.oe_n, 1'b1);
	endtask : t_config

	task automatic t_reconfig();
		fork
			host.pulse_req(250);
			begin
				step(101);
				check({status_pin.oe_n, done_pin.oe_n, user_mode}, 3'h0);
			end
		join
		wait_hi(0, n);
		check(n + 251 >= RST, 1'b1);
		check(n <= 12500, 1'b1);
	endtask : t_reconfig

	task automatic t_error();
		@(posedge sys_clk_i);
		auto_rst <= 1'b1;
		host.send_bits(PAT, 20);
		cfg_err <= 1'b1;
		step(2);
		check({status_pin.oe_n, done_pin.oe_n}, 2'h0);
		@(posedge sys_clk_i);
		cfg_err <= 1'b0;
		wait_hi(0, n);
		check(n + 3 >= RST && n <= RST + 20, 1'b1);
		// without auto restart the error holds status low until a fresh request
		@(posedge sys_clk_i);
		auto_rst <= 1'b0;
		host.send_bits(PAT, 4);
		cfg_err <= 1'b1;
		@(posedge sys_clk_i);
		cfg_err <= 1'b0;
		step(RST + 100);
		check(status_pin.oe_n, 1'b0);
		host.pulse_req(250);
		wait_hi(0, n);
		check(n <= RST, 1'b1);
	endtask : t_error

	initial begin
		repeat (8) @(posedge sys_clk_i);
		resetn_i <= 1'b1;
		t_power_up();
		t_config(1'b0, PAT);
		t_reconfig();
		t_config(1'b1, ~PAT);
		t_reconfig();
		t_error();
		close_out();
	end
endmodule : psc_top_test
